//--- logic/asrd_pkg.sv
package asrd_pkg;
  // result width and shift count
  localparam int RESULT_W  = 16;
  localparam int CNT_W     = 5;
  localparam logic [CNT_W-1:0] CNT_FULL = 5'h10;
  localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
  localparam logic [RESULT_W-1:0] RESULT_RST = 16'h0000;
  // readout method selected by the read-during input level
  typedef enum logic [1:0] {
    ASRD_RD_AFTER  = 2'b01,
    ASRD_RD_DURING = 2'b10
  } asrd_method_e;
  // conversion-side inputs that travel together
  typedef struct packed {
    logic                busy;
    logic [RESULT_W-1:0] result;
  } asrd_conv_s;
endpackage

//--- logic/asrd_serial_readout.sv
`timescale 1ns/1ns
// Overview of operation
// - read-during-conversion: while selected in conversion, previous result is shifted out
// - result goes out msb first over 16 external clocks, stable across both edges
// - in read-during-conversion method, unread result at conversion end gives a high pulse on the incomplete-read flag
// - no daisy chain in read-during-conversion method
// - daisy chain is offered when reading after conversion
// - chip select and read enable are combined; either high floats the serial result output
// - shift clock edges are ignored while chip select is high
module asrd_serial_readout (
  input  wire logic                     i_clock,
  input  wire logic                     i_rst_b,
  input  wire asrd_pkg::asrd_conv_s     i_conv,
  input  wire logic                     i_cs_n,
  input  wire logic                     i_rd_n,
  input  wire logic                     i_sclk,
  input  wire logic                     i_chain_input_pin,
  input  wire logic                     i_read_during,
  output logic                          o_serial_result_out,
  output logic                          o_serial_result_out_oe,
  output logic                          o_incomplete_read_flag
);
  import asrd_pkg::*;

  // reset release through two flops
  logic rst_meta_ff;
  logic rst_ff;
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_meta_ff <= 1'b0;
      rst_ff      <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_ff      <= rst_meta_ff;
    end
  end
  wire rst_b = rst_ff;

  // pin synchronisers; first stage is only read by the second
  // reset levels match the idle pins (clock idles low) so no false edge follows reset
  logic [3:0] sync1_ff;
  logic [3:0] sync2_ff;
  logic       sclk_d_ff;
  always_ff @(posedge i_clock or negedge rst_b) begin
    if (!rst_b) begin
      sync1_ff  <= 4'hD;
      sync2_ff  <= 4'hD;
      sclk_d_ff <= 1'b0;
    end else begin
      sync1_ff  <= {i_cs_n, i_rd_n, i_sclk, i_chain_input_pin};
      sync2_ff  <= sync1_ff;
      sclk_d_ff <= sync2_ff[1];
    end
  end
  wire cs_n_s  = sync2_ff[3];
  wire rd_n_s  = sync2_ff[2];
  wire sclk_s  = sync2_ff[1];
  wire chain_s = sync2_ff[0];

  // method is a same-domain level from the mode logic
  wire asrd_method_e method = i_read_during ? ASRD_RD_DURING : ASRD_RD_AFTER;

  // busy edge detection
  logic busy_d_ff;
  always_ff @(posedge i_clock or negedge rst_b) begin
    if (!rst_b) busy_d_ff <= 1'b0;
    else busy_d_ff <= i_conv.busy;
  end
  wire conv_done = busy_d_ff && !i_conv.busy;

  // decode of interface enables and clock edges
  wire sel      = !(cs_n_s || rd_n_s);
  wire sclk_en  = !cs_n_s;
  wire sclk_rise = sclk_en && sclk_s && !sclk_d_ff;
  wire sclk_fall = sclk_en && !sclk_s && sclk_d_ff;
  // cpha=0 idle low: shift on falling edge, chain bit latched on rising edge
  wire chain_on = (method == ASRD_RD_AFTER);

  logic [RESULT_W-1:0] shift_ff;
  logic [CNT_W-1:0]    cnt_ff;
  logic                chain_bit_ff;
  logic                sdo_ff;
  logic                oe_ff;
  logic                err_ff;
  logic                first_ff;

  wire unread = (cnt_ff != CNT_FULL);
  wire chain_in = chain_on ? chain_bit_ff : 1'b0;       // pin level ignored in read-during method
  wire [RESULT_W-1:0] nxt_shift = {shift_ff[RESULT_W-2:0], chain_in};
  wire [CNT_W-1:0]    nxt_cnt   = (cnt_ff == CNT_FULL) ? cnt_ff : cnt_ff + 5'h01;
  // first edge opens bit msb (already on pin); later falls advance
  wire adv = sel && sclk_fall && !first_ff;

  // shift register, bit count and rising-edge latch of the chain input
  always_ff @(posedge i_clock or negedge rst_b) begin
    if (!rst_b) begin
      shift_ff     <= RESULT_RST;
      cnt_ff       <= CNT_FULL;
      chain_bit_ff <= 1'b0;
      first_ff     <= 1'b1;
    end else begin
      if (sel && sclk_rise) chain_bit_ff <= chain_s;
      if (conv_done) begin
        shift_ff <= i_conv.result;
        cnt_ff   <= CNT_ZERO;
        first_ff <= 1'b1;
      end else if (sel && sclk_rise && first_ff) begin
        first_ff <= 1'b0;
        cnt_ff   <= nxt_cnt;
      end else if (adv) begin
        shift_ff <= nxt_shift;
        cnt_ff   <= nxt_cnt;
      end
    end
  end

  // output pin: bit held between falling edges so both edges see it
  always_ff @(posedge i_clock or negedge rst_b) begin
    if (!rst_b) begin
      sdo_ff <= 1'b0;
      oe_ff  <= 1'b0;
    end else begin
      sdo_ff <= conv_done ? i_conv.result[RESULT_W-1]
                          : (adv ? nxt_shift[RESULT_W-1] : shift_ff[RESULT_W-1]);
      oe_ff  <= sel;
    end
  end

  // one-cycle error pulse when a conversion ends before the read finished in read-during method
  always_ff @(posedge i_clock or negedge rst_b) begin
    if (!rst_b) err_ff <= 1'b0;
    else err_ff <= conv_done && unread && (method == ASRD_RD_DURING);
  end

  assign o_serial_result_out    = sdo_ff;
  assign o_serial_result_out_oe = oe_ff;
  assign o_incomplete_read_flag = err_ff;

  a_err_pulse: assert property (@(posedge i_clock) disable iff (!rst_b)
    (conv_done && unread && i_read_during) |=> o_incomplete_read_flag)
    else $error("incomplete read not flagged");
  a_err_once: assert property (@(posedge i_clock) disable iff (!rst_b)
    o_incomplete_read_flag |=> !o_incomplete_read_flag)
    else $error("error flag longer than one cycle");
  a_err_cause: assert property (@(posedge i_clock) disable iff (!rst_b)
    o_incomplete_read_flag |-> $past(conv_done))
    else $error("error flag without conversion end");
  a_oe_deselect: assert property (@(posedge i_clock) disable iff (!rst_b)
    (cs_n_s || rd_n_s) |=> !o_serial_result_out_oe)
    else $error("output driven while deselected");
  a_oe_select: assert property (@(posedge i_clock) disable iff (!rst_b)
    sel |=> o_serial_result_out_oe)
    else $error("output not driven while selected");
  a_load_msb: assert property (@(posedge i_clock) disable iff (!rst_b)
    conv_done |=> (o_serial_result_out == $past(i_conv.result[RESULT_W-1])) && cnt_ff == CNT_ZERO)
    else $error("result msb not presented after conversion");
  a_gate_cs: assert property (@(posedge i_clock) disable iff (!rst_b)
    (cs_n_s && !conv_done) |=> $stable(shift_ff) && $stable(cnt_ff))
    else $error("shift moved while chip select high");
  a_bit_stable: assert property (@(posedge i_clock) disable iff (!rst_b)
    (!adv && !conv_done) |=> $stable(o_serial_result_out))
    else $error("data changed without falling edge");
  a_no_chain: assert property (@(posedge i_clock) disable iff (!rst_b)
    (adv && i_read_during) |=> shift_ff[0] == 1'b0)
    else $error("chain input used in read-during method");

  // bit counter and shift path checks
  a_cnt_bound: assert property (@(posedge i_clock) disable iff (!rst_b)
    cnt_ff <= CNT_FULL)
    else $error("bit count beyond a full word");

  a_count_step: assert property (@(posedge i_clock) disable iff (!rst_b)
    (adv && !conv_done && cnt_ff != CNT_FULL) |=> cnt_ff != $past(cnt_ff))
    else $error("falling edge did not count a bit");

  a_shift_msb: assert property (@(posedge i_clock) disable iff (!rst_b)
    (adv && !conv_done) |=> o_serial_result_out == $past(shift_ff[RESULT_W-2]))
    else $error("next bit not presented after falling edge");

  a_rise_no_shift: assert property (@(posedge i_clock) disable iff (!rst_b)
    (sel && sclk_rise && !conv_done) |=> $stable(shift_ff))
    else $error("shift register moved on a rising edge");

  a_first_rise: assert property (@(posedge i_clock) disable iff (!rst_b)
    (sel && sclk_rise && first_ff && !conv_done) |=> !first_ff)
    else $error("first rising edge did not open the word");

  // the load at conversion end must win over any shift in the same cycle
  a_load_result: assert property (@(posedge i_clock) disable iff (!rst_b)
    conv_done |=> shift_ff == $past(i_conv.result))
    else $error("result not loaded at conversion end");

  // read enable high holds the shifter even with chip select low
  a_rd_gate: assert property (@(posedge i_clock) disable iff (!rst_b)
    (rd_n_s && !conv_done) |=> $stable(shift_ff) && $stable(cnt_ff))
    else $error("shift moved while read enable high");

  a_sdo_hold: assert property (@(posedge i_clock) disable iff (!rst_b)
    (!sel && !conv_done) |=> $stable(o_serial_result_out))
    else $error("data changed while deselected");

  // chain data only enters the word when reading after conversion
  a_chain_after: assert property (@(posedge i_clock) disable iff (!rst_b)
    (adv && !i_read_during && !conv_done) |=> shift_ff[0] == $past(chain_bit_ff))
    else $error("chain bit not shifted in after conversion");

  // error flag belongs to the read-during method only
  a_err_method: assert property (@(posedge i_clock) disable iff (!rst_b)
    o_incomplete_read_flag |-> $past(i_read_during))
    else $error("error flag outside read-during method");

  a_err_quiet: assert property (@(posedge i_clock) disable iff (!rst_b)
    (conv_done && !unread) |=> !o_incomplete_read_flag)
    else $error("error flag after a complete read");

  a_err_after: assert property (@(posedge i_clock) disable iff (!rst_b)
    (conv_done && !i_read_during) |=> !o_incomplete_read_flag)
    else $error("error flag in read-after method");
endmodule

//--- testbench/asrd_host_model.sv
`timescale 1ns/1ns
// spi host master: idle-low clock, captures each bit just before the rising edge
module asrd_host_model (
  input  wire logic i_sdo,
  input  wire logic i_oe,
  output logic      o_sclk,
  output logic      o_cs_n,
  output logic      o_rd_n
);
  logic [15:0] word;
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_rd_n = 1'b1;
  end
  // a released line reads as the inverse, so a stale bit never passes
  task automatic read_bits(input int n, input logic sel);
    word = 16'h0000;
    o_cs_n = ~sel;
    o_rd_n = 1'b0;
    #100;
    for (int k = 0; k < n; k++) begin
      #60 word = {word[14:0], i_oe ? i_sdo : ~i_sdo};
      o_sclk = 1'b1;
      #65 o_sclk = 1'b0;
    end
    #60 o_cs_n = 1'b1;
    o_rd_n = 1'b1;
  endtask
endmodule

//--- testbench/tb.sv
`timescale 1ns/1ns
module tb;
  import asrd_pkg::*;
  logic       i_clock = 1'b0;
  logic       i_rst_b = 1'b0;
  logic       rd_dur  = 1'b0;
  logic       chain_pin = 1'b1; // held at one fixed level all run
  logic       sdo, oe, flag, sclk, cs_n, rd_n;
  asrd_conv_s conv    = '0;
  int         failures = 0;
  int         n_compared = 0;
  int         flags = 0;
  logic [15:0] rows [4] = '{16'h8001, 16'hFFFF, 16'h0000, 16'hA5C3};
  always #5 i_clock = ~i_clock;
  // count pulses on the falling edge, half a cycle after the launching edge, where the flag has settled
  always @(negedge i_clock) if (flag === 1'b1) flags++;
  asrd_serial_readout asrd_serial_readout_inst (.i_clock(i_clock), .i_rst_b(i_rst_b),
    .i_conv(conv), .i_cs_n(cs_n), .i_rd_n(rd_n), .i_sclk(sclk),
    .i_chain_input_pin(chain_pin), .i_read_during(rd_dur), .o_serial_result_out(sdo),
    .o_serial_result_out_oe(oe), .o_incomplete_read_flag(flag));
  asrd_host_model asrd_host_model_inst (.i_sdo(sdo), .i_oe(oe), .o_sclk(sclk),
    .o_cs_n(cs_n), .o_rd_n(rd_n));
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // busy level and result change together, then settle a few cycles
  task automatic set_busy(input logic b, input logic [15:0] res);
    @(negedge i_clock) conv = '{busy: b, result: res};
    repeat (4) @(negedge i_clock);
  endtask
  task automatic give_verdict();
    if (failures == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (6) @(negedge i_clock);
    i_rst_b = 1'b1;
    repeat (4) @(negedge i_clock);
    // serial port with external clock assumed selected no parallel path
    // read after conversion; stray clocks without select come first each time
    foreach (rows[i]) begin
      set_busy(1'b1, rows[i]);
      set_busy(1'b0, rows[i]);
      asrd_host_model_inst.read_bits(3, 1'b0);
      asrd_host_model_inst.read_bits(16, 1'b1);
      check(asrd_host_model_inst.word, rows[i]);
    end
    // a second word without a new conversion returns the chained-in level
    asrd_host_model_inst.read_bits(16, 1'b1);
    check(asrd_host_model_inst.word, 16'hFFFF);
    // read during the next conversion, completed in time
    rd_dur = 1'b1;
    set_busy(1'b1, 16'h1234);
    set_busy(1'b0, 16'h1234);
    set_busy(1'b1, 16'h5678);
    asrd_host_model_inst.read_bits(16, 1'b1);
    check(asrd_host_model_inst.word, 16'h1234);
    set_busy(1'b0, 16'h5678);
    check(16'(flags), 16'h0000);
    // half a word read when the conversion ends must raise one pulse
    set_busy(1'b1, 16'h9ABC);
    asrd_host_model_inst.read_bits(8, 1'b1);
    check(asrd_host_model_inst.word, 16'h0056);
    set_busy(1'b0, 16'h9ABC);
    check(16'(flags), 16'h0001);
    // reset in mid-run clears every output at once
    @(negedge i_clock) i_rst_b = 1'b0;
    #1 check({13'h0000, sdo, oe, flag}, 16'h0000);
    repeat (3) @(negedge i_clock);
    i_rst_b = 1'b1;
    repeat (3) @(negedge i_clock);
    check({13'h0000, sdo, oe, flag}, 16'h0000);
    check(16'(flags), 16'h0001);
    give_verdict();
  end
  // 11 reads of at most 2.16 us fit well inside this span
  initial begin
    #200000;
    failures++;
    give_verdict();
  end
endmodule
